// ==== core/cwep_cmd_core.sv ====
// Functional notes
// - single write: standard card uses set length, high-capacity always 512 bytes
// - multi write takes blocks until stop, each sized like single write
// - without partial writes, write length equals default length
// - capacity flag: address in bytes when 0, in 512-byte blocks when 1
// - block count command applies to next multi-block transfer
// - speed class code in bits 31:28, rest zero, busy response
// - csd programming updates only programmable bits
// - set protect bit of addressed group, busy response
// - clear protect bit of addressed group, busy response
// - protect status sends 32 bits then 16-bit crc on data line
// - least significant, last sent bit is first addressed group
// - groups outside valid range report zero
// - erase start command latches first block address
// - erase end command latches last block address
// - erase clears every block in range, busy until done
// - lock command data block sized by set block length
// - reserved indices are rejected as unsupported
// - block length above 512 raises block length error
`timescale 1ns/1ps
`default_nettype none
module cwep_cmd_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             dat0_o,
    output logic             dat0_oe_n,
    output logic             erase_stb,
    output logic      [31:0] erase_addr
);
    // ==========================================================
    // state
    cwep_pkg::cwep_st_t  st_q, st_d;
    cwep_pkg::cwep_cfg_t cfg_q, cfg_d;
    logic [31:0] arg_q, arg_d, blkcnt_q, blkcnt_d, rem_q, rem_d;
    logic [31:0] ers_s_q, ers_s_d, ers_e_q, ers_e_d, ers_c_q, ers_c_d;
    logic [31:0] csd_q, csd_d, csh_q, csh_d, prdata_q, prdata_d;
    logic [11:0] blklen_q, blklen_d, len_q, len_d, bcnt_q, bcnt_d;
    logic [5:0]  cmd_q, cmd_d, tbit_q, tbit_d;
    logic [47:0] tsh_q, tsh_d;
    logic [7:0]  bsy_q, bsy_d;
    logic [1:0]  div_q, div_d;
    logic [cwep_pkg::WP_GROUPS-1:0] wp_q, wp_d;
    logic        cntv_q, cntv_d, ersa_q, ersa_d, ill_q, ill_d, ble_q, ble_d;
    logic        rdy_q, rdy_d, err_q, err_d, dat_q, dat_d, oen_q, oen_d;
    logic        estb_q, estb_d;
    logic [31:0] eadr_q, eadr_d;
    // ==========================================================
    // address decode and helpers
    logic        acc, wacc, cmd_go, reserved, mapped;
    logic [5:0]  nidx;
    logic [31:0] blk_adr, grp, wp_word;
    logic [11:0] wr_len;
    assign acc    = psel & penable & rdy_q;
    assign wacc   = acc & pwrite;
    assign nidx   = pwdata[5:0];
    assign cmd_go = wacc && paddr == cwep_pkg::ADR_CMD && st_q == cwep_pkg::ST_IDLE;
    assign mapped = paddr <= cwep_pkg::ADR_CSD && paddr[1:0] == 2'b00;
    assign reserved = nidx inside {6'd26, 6'd31, 6'd39, 6'd40, 6'd41, [6'd43:6'd49], 6'd51};
    assign blk_adr = cfg_q.ccs ? arg_q : (arg_q >> cwep_pkg::BLK_SHIFT);
    assign grp     = blk_adr >> cfg_q.grp_shift;
    assign wr_len = (cfg_q.ccs || !cfg_q.partial) ? cwep_pkg::DEF_BLKLEN : blklen_q;
    for (genvar i = 0; i < 32; i++)
    begin : g_wp
        logic [31:0] g;
        assign g          = grp + 32'(i);
        assign wp_word[i] = (g < cwep_pkg::WP_GROUPS) ? wp_q[g[cwep_pkg::WP_IDX_W-1:0]] : 1'b0;
    end
    function automatic logic [15:0] crc16(input logic [31:0] d);
        logic [15:0] c;
        logic        fb;
        c = 16'h0000;
        for (int i = 31; i >= 0; i--)
        begin
            fb = d[i] ^ c[15];
            c  = {c[14:0], 1'b0};
            if (fb)
                c = c ^ cwep_pkg::CRC_POLY;
        end
        return c;
    endfunction : crc16
    // ==========================================================
    // next state
    always_comb
    begin
        st_d = st_q; cfg_d = cfg_q; arg_d = arg_q; blkcnt_d = blkcnt_q; rem_d = rem_q;
        ers_s_d = ers_s_q; ers_e_d = ers_e_q; ers_c_d = ers_c_q; csd_d = csd_q; csh_d = csh_q;
        blklen_d = blklen_q; len_d = len_q; bcnt_d = bcnt_q; cmd_d = cmd_q; tbit_d = tbit_q;
        tsh_d = tsh_q; bsy_d = bsy_q; div_d = div_q; wp_d = wp_q; cntv_d = cntv_q;
        ersa_d = ersa_q; ill_d = ill_q; ble_d = ble_q; estb_d = 1'b0; eadr_d = eadr_q;
        rdy_d = psel & penable & ~rdy_q;
        err_d = psel & penable & ~rdy_q & ~mapped;
        prdata_d = prdata_q;
        dat_d = 1'b1; oen_d = 1'b1;
        // apb register reads
        if (psel && penable && !rdy_q && !pwrite)
        begin
            unique case (paddr)
                cwep_pkg::ADR_ARG:  prdata_d = arg_q;
                cwep_pkg::ADR_STAT: prdata_d = {26'h0, st_q, cntv_q, ersa_q, ble_q, ill_q};
                cwep_pkg::ADR_WPW:  prdata_d = wp_word;
                cwep_pkg::ADR_BLEN: prdata_d = {20'h0, blklen_q};
                cwep_pkg::ADR_CFG:  prdata_d = {24'h0, cfg_q};
                cwep_pkg::ADR_ERSS: prdata_d = ers_s_q;
                cwep_pkg::ADR_ERSE: prdata_d = ers_e_q;
                cwep_pkg::ADR_CSD:  prdata_d = csd_q;
                default:            prdata_d = 32'h0000_0000;
            endcase
        end
        // apb register writes
        if (wacc && paddr == cwep_pkg::ADR_ARG)
            arg_d = pwdata;
        if (wacc && paddr == cwep_pkg::ADR_CFG)
            cfg_d = pwdata[7:0];
        if (wacc && paddr == cwep_pkg::ADR_STAT)
        begin
            ill_d = ill_q & ~pwdata[cwep_pkg::ST_ILL];
            ble_d = ble_q & ~pwdata[cwep_pkg::ST_BLE];
        end
        // command execution
        if (cmd_go)
        begin
            cmd_d = nidx;
            if (reserved)
                ill_d = 1'b1;
            else
            begin
                unique case (nidx)
                    cwep_pkg::C_SBLEN:
                        if (arg_q > 32'(cwep_pkg::DEF_BLKLEN))
                            ble_d = 1'b1;
                        else
                            blklen_d = arg_q[11:0];
                    cwep_pkg::C_SPEED:
                    begin
                        if (arg_q[27:0] != 28'h000_0000)
                            ill_d = 1'b1;
                        else
                        begin
                            st_d  = cwep_pkg::ST_BUSY;
                            bsy_d = cwep_pkg::R1B_CNT;
                        end
                    end
                    cwep_pkg::C_SCNT:
                    begin
                        blkcnt_d = arg_q;
                        cntv_d   = 1'b1;
                    end
                    cwep_pkg::C_WR1, cwep_pkg::C_WRM:
                    begin
                        st_d   = cwep_pkg::ST_RX;
                        len_d  = wr_len;
                        bcnt_d = 12'h000;
                        rem_d  = blkcnt_q;
                    end
                    cwep_pkg::C_PCSD:
                    begin
                        st_d   = cwep_pkg::ST_RX;
                        len_d  = cwep_pkg::CSD_LEN;
                        bcnt_d = 12'h000;
                    end
                    cwep_pkg::C_LOCK:
                    begin
                        st_d   = cwep_pkg::ST_RX;
                        len_d  = blklen_q;
                        bcnt_d = 12'h000;
                    end
                    cwep_pkg::C_SWP, cwep_pkg::C_CWP:
                    begin
                        if (cfg_q.wp_en && grp < cwep_pkg::WP_GROUPS)
                            wp_d[grp[cwep_pkg::WP_IDX_W-1:0]] = (nidx == cwep_pkg::C_SWP);
                        st_d  = cwep_pkg::ST_BUSY;
                        bsy_d = cwep_pkg::R1B_CNT;
                    end
                    // word plus crc queued for sending
                    cwep_pkg::C_GWP:
                    begin
                        st_d   = cwep_pkg::ST_TX;
                        tsh_d  = {wp_word, crc16(wp_word)};
                        tbit_d = 6'h00;
                        div_d  = 2'h0;
                    end
                    cwep_pkg::C_ERS:   ers_s_d = blk_adr;
                    cwep_pkg::C_ERE:   ers_e_d = blk_adr;
                    cwep_pkg::C_ERASE:
                    begin
                        st_d    = cwep_pkg::ST_BUSY;
                        ersa_d  = ers_s_q <= ers_e_q;
                        ers_c_d = ers_s_q;
                        bsy_d   = cwep_pkg::R1B_CNT;
                    end
                    default: ;
                endcase
            end
        end
        unique case (st_q)
            cwep_pkg::ST_IDLE: ;
            cwep_pkg::ST_RX:
            begin
                if (wacc && paddr == cwep_pkg::ADR_CMD && nidx == cwep_pkg::C_STOP)
                begin
                    st_d   = cwep_pkg::ST_BUSY;
                    bsy_d  = cwep_pkg::R1B_CNT;
                    cntv_d = 1'b0;
                end
                else if (wacc && paddr == cwep_pkg::ADR_DATA)
                begin
                    csh_d  = {csh_q[23:0], pwdata[7:0]};
                    bcnt_d = bcnt_q + 12'h001;
                    if (bcnt_q + 12'h001 >= len_q)
                    begin
                        bcnt_d = 12'h000;
                        if (cmd_q == cwep_pkg::C_PCSD)
                            csd_d = (csd_q & ~cwep_pkg::CSD_PROG_MASK)
                                  | ({csh_q[23:0], pwdata[7:0]} & cwep_pkg::CSD_PROG_MASK);
                        if (cmd_q != cwep_pkg::C_WRM)
                            st_d = cwep_pkg::ST_IDLE;
                        else if (cntv_q)
                        begin
                            rem_d = rem_q - 32'h0000_0001;
                            if (rem_q <= 32'h0000_0001)
                            begin
                                st_d   = cwep_pkg::ST_IDLE;
                                cntv_d = 1'b0;
                            end
                        end
                    end
                end
            end
            cwep_pkg::ST_BUSY:
            begin
                dat_d = 1'b0;
                oen_d = 1'b0;
                if (ersa_q)
                begin
                    estb_d  = 1'b1;
                    eadr_d  = ers_c_q;
                    ers_c_d = ers_c_q + 32'h0000_0001;
                    ersa_d  = ers_c_q != ers_e_q;
                end
                else if (bsy_q != 8'h00)
                    bsy_d = bsy_q - 8'h01;
                else
                begin
                    st_d  = cwep_pkg::ST_IDLE;
                    dat_d = 1'b1;
                    oen_d = 1'b1;
                end
            end
            cwep_pkg::ST_TX:
            begin
                oen_d = 1'b0;
                dat_d = dat_q;
                div_d = div_q + 2'h1;
                if (div_q == 2'h0)
                begin
                    // start bit, 48 payload bits msb first, end bit
                    if (tbit_q == 6'h00)
                        dat_d = 1'b0;
                    else if (tbit_q <= 6'h30)
                    begin
                        dat_d = tsh_q[47];
                        tsh_d = {tsh_q[46:0], 1'b0};
                    end
                    else
                        dat_d = 1'b1;
                end
                if (div_q == cwep_pkg::TX_DIV_MAX)
                begin
                    tbit_d = tbit_q + 6'h01;
                    if (tbit_q == cwep_pkg::TX_BITS)
                    begin
                        st_d  = cwep_pkg::ST_IDLE;
                        oen_d = 1'b1;
                        dat_d = 1'b1;
                    end
                end
            end
        endcase
    end
    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= cwep_pkg::ST_IDLE; cfg_q <= cwep_pkg::CFG_RST; arg_q <= '0; blkcnt_q <= '0;
            rem_q <= '0; ers_s_q <= '0; ers_e_q <= '0; ers_c_q <= '0; csd_q <= '0; csh_q <= '0;
            blklen_q <= cwep_pkg::DEF_BLKLEN; len_q <= cwep_pkg::DEF_BLKLEN; bcnt_q <= '0;
            cmd_q <= '0; tbit_q <= '0; tsh_q <= '0; bsy_q <= '0; div_q <= '0; wp_q <= '0;
            cntv_q <= 1'b0; ersa_q <= 1'b0; ill_q <= 1'b0; ble_q <= 1'b0; rdy_q <= 1'b0;
            err_q <= 1'b0; prdata_q <= '0; dat_q <= 1'b1; oen_q <= 1'b1; estb_q <= 1'b0;
            eadr_q <= '0;
        end
        else
        begin
            st_q <= st_d; cfg_q <= cfg_d; arg_q <= arg_d; blkcnt_q <= blkcnt_d; rem_q <= rem_d;
            ers_s_q <= ers_s_d; ers_e_q <= ers_e_d; ers_c_q <= ers_c_d; csd_q <= csd_d;
            csh_q <= csh_d; blklen_q <= blklen_d; len_q <= len_d; bcnt_q <= bcnt_d;
            cmd_q <= cmd_d; tbit_q <= tbit_d; tsh_q <= tsh_d; bsy_q <= bsy_d; div_q <= div_d;
            wp_q <= wp_d; cntv_q <= cntv_d; ersa_q <= ersa_d; ill_q <= ill_d; ble_q <= ble_d;
            rdy_q <= rdy_d; err_q <= err_d; prdata_q <= prdata_d; dat_q <= dat_d;
            oen_q <= oen_d; estb_q <= estb_d; eadr_q <= eadr_d;
        end
    end
    assign prdata     = prdata_q;
    assign pready     = rdy_q;
    assign pslverr    = err_q;
    assign dat0_o     = dat_q;
    assign dat0_oe_n  = oen_q;
    assign erase_stb  = estb_q;
    assign erase_addr = eadr_q;
    // ==========================================================
    // checks
    sequence s_cmd(logic [5:0] idx);
        cmd_go && nidx == idx && !reserved;
    endsequence
    blklen_err_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_SBLEN) and arg_q > 32'h0000_0200 |=> ble_q && $stable(blklen_q))
        else $error("block length error not raised");
    hc_len_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_WR1) and cfg_q.ccs |=> len_q == 12'h200 && st_q == cwep_pkg::ST_RX)
        else $error("high capacity write length wrong");
    reserved_cmd_a : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && reserved |=> ill_q && st_q == cwep_pkg::ST_IDLE)
        else $error("reserved command accepted");
    busy_line_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_q == cwep_pkg::ST_BUSY && $past(st_q) == cwep_pkg::ST_BUSY |-> !dat0_oe_n && !dat0_o)
        else $error("data line 0 not held low while busy");
    wp_set_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_SWP) and cfg_q.wp_en && grp < 32'h0000_0040 |=> wp_q[$past(grp[5:0])])
        else $error("protect bit not set");
    wp_clr_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_CWP) and cfg_q.wp_en && grp < 32'h0000_0040 |=> !wp_q[$past(grp[5:0])])
        else $error("protect bit not cleared");
    tx_frame_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_GWP) |=> ##1 (!dat0_o && !dat0_oe_n)[*4] ##[190:200] st_q == cwep_pkg::ST_IDLE)
        else $error("protect status frame malformed");
    erase_rng_a : assert property (@(posedge pclk) disable iff (!presetn)
        erase_stb |-> erase_addr >= ers_s_q && erase_addr <= ers_e_q && st_q == cwep_pkg::ST_BUSY)
        else $error("erase outside latched range");
    erase_latch_a : assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd(cwep_pkg::C_ERS) |=> ers_s_q == $past(blk_adr))
        else $error("erase start not latched");
    stop_multi_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_q == cwep_pkg::ST_RX && wacc && paddr == cwep_pkg::ADR_CMD && nidx == cwep_pkg::C_STOP
        |=> st_q == cwep_pkg::ST_BUSY)
        else $error("stop did not end transfer");
endmodule : cwep_cmd_core
`default_nettype wire

// ==== core/cwep_pkg.sv ====
`default_nettype none
package cwep_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_MHZ     = 20;
    localparam int unsigned R1B_BUSY_NS = 2000;
    localparam int unsigned R1B_CYC     = (R1B_BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  R1B_CNT     = 8'(R1B_CYC);
    localparam logic [1:0]  TX_DIV_MAX  = 2'h3;
    localparam logic [5:0]  TX_BITS     = 6'h31;
    // ==========================================================
    // lengths and geometry
    localparam logic [11:0] DEF_BLKLEN  = 12'h200;
    localparam logic [11:0] CSD_LEN     = 12'h010;
    localparam int unsigned BLK_SHIFT   = 9;
    localparam int unsigned WP_GROUPS   = 64;
    localparam int unsigned WP_IDX_W    = 6;
    localparam logic [15:0] CRC_POLY    = 16'h1021;
    localparam logic [31:0] CSD_PROG_MASK = 32'h0000_FFFE;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADR_ARG  = 8'h00;
    localparam logic [7:0] ADR_CMD  = 8'h04;
    localparam logic [7:0] ADR_DATA = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    localparam logic [7:0] ADR_WPW  = 8'h10;
    localparam logic [7:0] ADR_BLEN = 8'h14;
    localparam logic [7:0] ADR_CFG  = 8'h18;
    localparam logic [7:0] ADR_ERSS = 8'h1C;
    localparam logic [7:0] ADR_ERSE = 8'h20;
    localparam logic [7:0] ADR_CSD  = 8'h24;
    // status bit positions
    localparam int unsigned ST_ILL = 0;
    localparam int unsigned ST_BLE = 1;
    // ==========================================================
    // command indices
    localparam logic [5:0] C_STOP = 6'h0C, C_SBLEN = 6'h10, C_SPEED = 6'h14, C_SCNT = 6'h17;
    localparam logic [5:0] C_WR1 = 6'h18, C_WRM = 6'h19, C_PCSD = 6'h1B, C_SWP = 6'h1C;
    localparam logic [5:0] C_CWP = 6'h1D, C_GWP = 6'h1E, C_ERS = 6'h20, C_ERE = 6'h21;
    localparam logic [5:0] C_ERASE = 6'h26, C_LOCK = 6'h2A;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX   = 2'b01,
        ST_BUSY = 2'b11,
        ST_TX   = 2'b10
    } cwep_st_t;
    typedef struct packed {
        logic       ccs;
        logic       partial;
        logic       wp_en;
        logic [4:0] grp_shift;
    } cwep_cfg_t;
    localparam cwep_cfg_t CFG_RST = '{ccs: 1'b0, partial: 1'b0, wp_en: 1'b1, grp_shift: 5'h00};
endpackage : cwep_pkg
`default_nettype wire

// ==== verification/cwep_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================================
// host end of data line 0
module cwep_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        dat0_o,
    input  wire logic        dat0_oe_n,
    output logic             dat0_line,
    output logic      [47:0] frame_q
);
    int n_q;
    // pull-up wins when the card lets go
    assign dat0_line = dat0_oe_n ? 1'b1 : dat0_o;
    // sample mid-cell, skipping the start bit: 32 protect bits and 16 crc bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            n_q <= 0;
        else if (dat0_oe_n)
            n_q <= 0;
        else
        begin
            n_q <= n_q + 1;
            if (n_q % 4 == 2 && n_q > 4 && n_q < 196)
                frame_q <= {frame_q[46:0], dat0_line};
        end
    end
endmodule : cwep_host_model
`default_nettype wire

// ==== verification/test_card_write_erase_protect_cmds.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; $display("Error %0t got %h exp %h", $time, a, e); end end
module test_card_write_erase_protect_cmds;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, erase_addr, w;
    logic        pready, pslverr, dat0_o, dat0_oe_n, erase_stb, dat0_line, se;
    logic [47:0] frame_q;
    logic [63:0] prot;
    logic [31:0] eq[$];
    int          errors = 0, checks_done = 0, cyc = 0, b, s, e, g;
    int          res[13] = '{26, 31, 39, 40, 41, 43, 44, 45, 46, 47, 48, 49, 51};
    always #25 pclk = ~pclk;
    cwep_cmd_core u_cwep_cmd_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dat0_o(dat0_o), .dat0_oe_n(dat0_oe_n), .erase_stb(erase_stb), .erase_addr(erase_addr));
    cwep_host_model u_cwep_host_model (.pclk(pclk), .presetn(presetn), .dat0_o(dat0_o),
        .dat0_oe_n(dat0_oe_n), .dat0_line(dat0_line), .frame_q(frame_q));
    // ====================================
    // erase strobe log and hang guard
    always @(posedge pclk)
    begin
        if (erase_stb === 1'b1)
            eq.push_back(erase_addr);
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            wrap_up();
        end
    end
    // ====================================
    // bus tasks and expectations
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
        xfer(1'b1, cwep_pkg::ADR_ARG, arg);
        xfer(1'b1, cwep_pkg::ADR_CMD, {26'h0, idx});
    endtask : cmd
    task automatic idle_wait();
        for (int i = 0; i < 600; i++)
        begin
            xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
            if (rd[5:4] === 2'b00)
                break;
        end
        `CHK(rd[5:4], 2'b00)
    endtask : idle_wait
    // n random data bytes, which may span several blocks
    task automatic blk(input int n);
        repeat (n) xfer(1'b1, cwep_pkg::ADR_DATA, $urandom);
    endtask : blk
    task automatic xlen(input logic [5:0] idx, input int n);
        cmd(idx, 32'h0000_0000);
        blk(n - 1);
        xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
        `CHK(rd[5:4], 2'b01)
        blk(1);
        xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
        `CHK(rd[5:4] === 2'b01, 1'b0)
        idle_wait();
    endtask : xlen
    function automatic logic [31:0] exp_wpw(input int gr);
        logic [31:0] r;
        for (int i = 0; i < 32; i++)
            r[i] = (gr + i < 64) ? prot[gr + i] : 1'b0;
        return r;
    endfunction : exp_wpw
    function automatic logic [15:0] crc16(input logic [31:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 31; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? cwep_pkg::CRC_POLY : 16'h0000);
        return c;
    endfunction : crc16
    // ====================================
    // main sequence
    initial
    begin
        void'($urandom(38301));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, cwep_pkg::ADR_BLEN, 32'h0000_0000);
        `CHK(rd[11:0], cwep_pkg::DEF_BLKLEN)
        b = 1 + $urandom % 511;
        cmd(cwep_pkg::C_SBLEN, b);
        cmd(cwep_pkg::C_SBLEN, 32'h0000_0201);
        xfer(1'b0, cwep_pkg::ADR_BLEN, 32'h0000_0000);
        `CHK(rd, 32'(b))
        xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        foreach (res[i])
        begin
            xfer(1'b1, cwep_pkg::ADR_STAT, 32'h0000_0003);
            cmd(6'(res[i]), 32'h0000_0000);
            xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
            `CHK(rd[1:0], 2'b01)
            `CHK(se, 1'b0)
        end
        xfer(1'b0, 8'h28, 32'h0000_0000);
        `CHK(se, 1'b1)
        `CHK(rd, 32'h0000_0000)
        xfer(1'b1, cwep_pkg::ADR_STAT, 32'h0000_0001);
        cmd(cwep_pkg::C_SPEED, 32'h5000_0001);
        xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
        `CHK(rd[5:0], 6'h01)
        xfer(1'b1, cwep_pkg::ADR_STAT, 32'h0000_0001);
        cmd(cwep_pkg::C_SPEED, 32'h5000_0000);
        repeat (2) @(posedge pclk);
        `CHK(dat0_line, 1'b0)
        idle_wait();
        xfer(1'b1, cwep_pkg::ADR_CFG, 32'h0000_0060);
        xlen(cwep_pkg::C_WR1, b);
        xlen(cwep_pkg::C_LOCK, b);
        xfer(1'b1, cwep_pkg::ADR_CFG, 32'h0000_00E0);
        xlen(cwep_pkg::C_WR1, 512);
        cmd(cwep_pkg::C_SCNT, 32'h0000_0002);
        xlen(cwep_pkg::C_WRM, 1024);
        cmd(cwep_pkg::C_WRM, 32'h0000_0000);
        blk(1024);
        xfer(1'b0, cwep_pkg::ADR_STAT, 32'h0000_0000);
        `CHK(rd[5:4], 2'b01)
        cmd(cwep_pkg::C_STOP, 32'h0000_0000);
        idle_wait();
        w = $urandom;
        cmd(cwep_pkg::C_PCSD, 32'h0000_0000);
        blk(12);
        for (int j = 3; j >= 0; j--)
            xfer(1'b1, cwep_pkg::ADR_DATA, w >> (8 * j));
        idle_wait();
        xfer(1'b0, cwep_pkg::ADR_CSD, 32'h0000_0000);
        `CHK(rd, w & cwep_pkg::CSD_PROG_MASK)
        xfer(1'b1, cwep_pkg::ADR_CFG, 32'h0000_0020);
        xlen(cwep_pkg::C_WR1, 512);
        s = $urandom % 100;
        e = s + $urandom % 4;
        cmd(cwep_pkg::C_ERS, (s << 9) | ($urandom % 512));
        cmd(cwep_pkg::C_ERE, e << 9);
        xfer(1'b0, cwep_pkg::ADR_ERSS, 32'h0000_0000);
        `CHK(rd, 32'(s))
        xfer(1'b0, cwep_pkg::ADR_ERSE, 32'h0000_0000);
        `CHK(rd, 32'(e))
        eq.delete();
        cmd(cwep_pkg::C_ERASE, 32'h0000_0000);
        idle_wait();
        `CHK(eq.size(), e - s + 1)
        foreach (eq[i]) `CHK(eq[i], 32'(s + i))
        xfer(1'b1, cwep_pkg::ADR_CFG, 32'h0000_00A1);
        cmd(cwep_pkg::C_SWP, 32'h0000_0000);
        idle_wait();
        prot = 64'h0000_0000_0000_0001;
        for (int k = 0; k < 4; k++)
        begin
            g = (k == 0) ? 62 : $urandom % 64;
            cmd(cwep_pkg::C_SWP, (g << 1) | 1);
            idle_wait();
            prot[g] = 1'b1;
            xfer(1'b0, cwep_pkg::ADR_WPW, 32'h0000_0000);
            `CHK(rd, exp_wpw(g))
            cmd(cwep_pkg::C_GWP, g << 1);
            idle_wait();
            `CHK(frame_q[47:16], exp_wpw(g))
            `CHK(frame_q[15:0], crc16(exp_wpw(g)))
            cmd(cwep_pkg::C_CWP, g << 1);
            idle_wait();
            prot[g] = 1'b0;
            xfer(1'b0, cwep_pkg::ADR_WPW, 32'h0000_0000);
            `CHK(rd, exp_wpw(g))
        end
        wrap_up();
    end
endmodule : test_card_write_erase_protect_cmds
`default_nettype wire
